// file: hw/scd_decoder.sv
// Command decoder for return-to-zero, sanitize and security-protocol-in.
//
// Decided for this implementation: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module scd_decoder #(
  parameter int PAT_DEPTH = 16,
  parameter int CNT_W = 5
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic seek_zero_req,
  input wire logic seek_done,
  output logic ovw_start,
  output logic [CNT_W-1:0] ovw_count,
  output logic crypto_start,
  output logic exit_fail_start,
  input wire logic san_done,
  input wire logic san_fail,
  input wire logic fill_block_start,
  input wire logic fill_next,
  input wire logic fill_prot,
  input wire logic fill_pass_end,
  output logic [7:0] fill_byte,
  output logic spi_start,
  output logic [7:0] spi_protocol,
  output logic spi_proto_info,
  output logic spi_pad_en,
  output logic [40:0] spi_max_bytes,
  output logic spi_no_data,
  input wire logic spo_result,
  input wire logic [7:0] spo_nexus,
  input wire logic lu_reset,
  input wire logic it_loss,
  input wire logic [7:0] it_loss_nexus
);
  localparam int PIW = $clog2(PAT_DEPTH);

  function automatic logic [7:0] cdb_byte(input logic [95:0] c, input int k);
    return c[8*k +: 8];
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Bus side registers.
  logic aw_held_r, w_held_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [31:0] cdb0_r, cdb1_r, cdb2_r, ovw_r, blk_r, nexus_r;
  logic [7:0] pat_mem [PAT_DEPTH];
  scd_pkg::scd_state_e state_r;
  logic done_r, check_r, failed_r, fail_failure_exit_permit_flag_r, immed_r, failure_exit_permit_flag_r, held_r;
  logic [3:0] sk_r;
  logic [7:0] asc_r;
  logic [7:0] held_nexus_r;
  logic invert_r, inv_r;
  logic [PIW-1:0] pidx_r;

  // Command field decoding; multi-byte fields are assembled MSB first.
  wire [95:0] cdb = {cdb2_r, cdb1_r, cdb0_r};
  wire [7:0] op = cdb_byte(cdb, 0);
  wire [7:0] b1 = cdb_byte(cdb, 1);
  wire [4:0] sa = b1[4:0];
  wire [15:0] san_pll = {cdb_byte(cdb, 7), cdb_byte(cdb, 8)};
  wire [31:0] alloc = {cdb_byte(cdb, 6), cdb_byte(cdb, 7),
                       cdb_byte(cdb, 8), cdb_byte(cdb, 9)};
  wire [7:0] b4 = cdb_byte(cdb, 4);
  wire inc512 = b4[scd_pkg::INC512_BIT];
  wire [15:0] pat_len = {ovw_r[23:16], ovw_r[31:24]};
  wire [CNT_W-1:0] cnt = ovw_r[CNT_W-1:0];

  wire wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;
  wire wr_map = awaddr_r inside {scd_pkg::OFF_CDB0, scd_pkg::OFF_CDB1,
                                 scd_pkg::OFF_CDB2, scd_pkg::OFF_CTRL,
                                 scd_pkg::OFF_OVW, scd_pkg::OFF_BLK,
                                 scd_pkg::OFF_PAT};
  wire go_wr = wr_fire && awaddr_r == scd_pkg::OFF_CTRL &&
               wstrb_r[0] && wdata_r[scd_pkg::CTRL_GO_BIT];
  wire go_acc = go_wr && state_r == scd_pkg::S_IDLE;

  wire is_rtz = op == scd_pkg::OP_RTZ;
  wire is_san = op == scd_pkg::OP_SAN;
  wire is_spi = op == scd_pkg::OP_SPI;
  wire sa_res = !(sa == scd_pkg::SA_OVW || sa == scd_pkg::SA_CRYPTO ||
                  sa == scd_pkg::SA_EXIT);
  wire exit_deny = sa == scd_pkg::SA_EXIT && failed_r && !fail_failure_exit_permit_flag_r;
  wire san_cdb_bad = san_pll != 16'h0000 || sa_res || exit_deny;
  wire pat_bad = pat_len == 16'h0000 || pat_len > blk_r[15:0] ||
                 pat_len > 16'(PAT_DEPTH);
  wire cnt_bad = cnt == '0;
  wire parm_bad = sa == scd_pkg::SA_OVW && (pat_bad || cnt_bad);
  wire spi_res = b1 > scd_pkg::PROTO_EXT_MAX;
  wire san_ok = is_san && !san_cdb_bad && !parm_bad;
  wire cmd_bad = !(is_rtz || is_san || is_spi);
  wire san_exit_act = sa == scd_pkg::SA_EXIT && failed_r;
  wire [40:0] spi_len = inc512 ?
      {alloc, 9'h000} : {9'h000, alloc};
  // The reading nexus rides on the go write itself; the register is stale.
  wire spi_read_own = go_acc && is_spi && !spi_res && held_r &&
      held_nexus_r == wdata_r[scd_pkg::NEXUS_LSB +: 8];
  wire held_clr = spi_read_own || lu_reset ||
                  (it_loss && it_loss_nexus == held_nexus_r);
  wire pat_wr = wr_fire && awaddr_r == scd_pkg::OFF_PAT && wstrb_r[0];
  wire [PIW-1:0] pat_last = PIW'(pat_len - 16'h0001);

  wire [31:0] status_word =
      {8'h00, asc_r, 4'h0, sk_r, 1'b0, spi_no_data, check_r, held_r,
       failed_r, state_r == scd_pkg::S_IDLE, state_r != scd_pkg::S_IDLE,
       done_r};
  wire rd_fire = s_axi_arvalid && s_axi_arready;
  wire rd_map = s_axi_araddr inside {scd_pkg::OFF_CDB0, scd_pkg::OFF_CDB1,
                                     scd_pkg::OFF_CDB2, scd_pkg::OFF_CTRL,
                                     scd_pkg::OFF_STATUS, scd_pkg::OFF_OVW,
                                     scd_pkg::OFF_BLK, scd_pkg::OFF_SPI_LEN};
  wire [31:0] rd_word =
      s_axi_araddr == scd_pkg::OFF_CDB0 ? cdb0_r :
      s_axi_araddr == scd_pkg::OFF_CDB1 ? cdb1_r :
      s_axi_araddr == scd_pkg::OFF_CDB2 ? cdb2_r :
      s_axi_araddr == scd_pkg::OFF_CTRL ? nexus_r :
      s_axi_araddr == scd_pkg::OFF_STATUS ? status_word :
      s_axi_araddr == scd_pkg::OFF_OVW ? ovw_r :
      s_axi_araddr == scd_pkg::OFF_BLK ? blk_r :
      s_axi_araddr == scd_pkg::OFF_SPI_LEN ? spi_max_bytes[31:0] : 32'h0;

  // AXI4-Lite write path: address and data are taken in either order.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= scd_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_r <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_map ? scd_pkg::RESP_OKAY : scd_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_held_r && !(s_axi_wvalid && s_axi_wready);
      s_axi_arready <= !s_axi_rvalid && !rd_fire;
    end
  end

  // AXI4-Lite read path.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= scd_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_map ? scd_pkg::RESP_OKAY : scd_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Software-written registers.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cdb0_r <= 32'h0;
      cdb1_r <= 32'h0;
      cdb2_r <= 32'h0;
      nexus_r <= 32'h0;
      ovw_r <= 32'h0;
      blk_r <= {16'h0000, scd_pkg::BLK_LEN_RST};
    end else if (wr_fire) begin
      unique case (awaddr_r)
        scd_pkg::OFF_CDB0: cdb0_r <= merge(cdb0_r, wdata_r, wstrb_r);
        scd_pkg::OFF_CDB1: cdb1_r <= merge(cdb1_r, wdata_r, wstrb_r);
        scd_pkg::OFF_CDB2: cdb2_r <= merge(cdb2_r, wdata_r, wstrb_r);
        scd_pkg::OFF_CTRL: nexus_r <= merge(nexus_r, wdata_r & 32'h0000ff00,
                                            wstrb_r);
        scd_pkg::OFF_OVW: ovw_r <= merge(ovw_r, wdata_r, wstrb_r);
        scd_pkg::OFF_BLK: blk_r <= merge(blk_r, wdata_r & 32'h0000ffff,
                                         wstrb_r);
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (pat_wr && wdata_r[scd_pkg::PAT_IDX_LSB +: 8] < 8'(PAT_DEPTH)) begin
      pat_mem[wdata_r[scd_pkg::PAT_IDX_LSB +: PIW]] <= wdata_r[7:0];
    end
  end

  // Command sequencing and completion status.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= scd_pkg::S_IDLE;
      done_r <= 1'b0;
      check_r <= 1'b0;
      sk_r <= scd_pkg::SK_GOOD;
      asc_r <= scd_pkg::ASC_NONE;
      immed_r <= 1'b0;
      failure_exit_permit_flag_r <= 1'b0;
      failed_r <= 1'b0;
      fail_failure_exit_permit_flag_r <= 1'b0;
    end else if (go_acc) begin
      done_r <= 1'b1;
      check_r <= 1'b1;
      sk_r <= scd_pkg::SK_ILLEGAL;
      asc_r <= scd_pkg::ASC_INV_CDB;
      if (is_rtz) begin
        state_r <= scd_pkg::S_SEEK;
        done_r <= 1'b0;
        check_r <= 1'b0;
        sk_r <= scd_pkg::SK_GOOD;
        asc_r <= scd_pkg::ASC_NONE;
      end else if (is_san && !san_cdb_bad && parm_bad) begin
        asc_r <= scd_pkg::ASC_INV_PARM;
      end else if (san_ok && sa == scd_pkg::SA_EXIT && !failed_r) begin
        // Nothing to leave: report good at once and start no engine.
        check_r <= 1'b0;
        sk_r <= scd_pkg::SK_GOOD;
        asc_r <= scd_pkg::ASC_NONE;
      end else if (san_ok) begin
        state_r <= scd_pkg::S_SAN;
        immed_r <= b1[scd_pkg::IMMED_BIT];
        failure_exit_permit_flag_r <= b1[scd_pkg::FAILURE_EXIT_PERMIT_FLAG_BIT];
        done_r <= b1[scd_pkg::IMMED_BIT];
        check_r <= 1'b0;
        sk_r <= scd_pkg::SK_GOOD;
        asc_r <= scd_pkg::ASC_NONE;
      end else if (is_spi && !spi_res) begin
        check_r <= 1'b0;
        sk_r <= scd_pkg::SK_GOOD;
        asc_r <= scd_pkg::ASC_NONE;
      end else if (cmd_bad) begin
        asc_r <= scd_pkg::ASC_INV_OP;
      end
    end else if (state_r == scd_pkg::S_SEEK && seek_done) begin
      state_r <= scd_pkg::S_IDLE;
      done_r <= 1'b1;
    end else if (state_r == scd_pkg::S_SAN && san_done) begin
      state_r <= scd_pkg::S_IDLE;
      failed_r <= san_fail;
      fail_failure_exit_permit_flag_r <= san_fail ? failure_exit_permit_flag_r : fail_failure_exit_permit_flag_r;
      if (!immed_r) begin
        done_r <= 1'b1;
        check_r <= san_fail;
        sk_r <= san_fail ? scd_pkg::SK_MEDIUM : scd_pkg::SK_GOOD;
        asc_r <= san_fail ? scd_pkg::ASC_SAN_FAIL : scd_pkg::ASC_NONE;
      end
    end else if (go_wr) begin
      done_r <= 1'b0;
    end
  end

  // Engine strobes; each is a one-cycle pulse from a flip-flop.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      seek_zero_req <= 1'b0;
      ovw_start <= 1'b0;
      ovw_count <= '0;
      invert_r <= 1'b0;
      crypto_start <= 1'b0;
      exit_fail_start <= 1'b0;
      spi_start <= 1'b0;
      spi_protocol <= 8'h00;
      spi_proto_info <= 1'b0;
      spi_pad_en <= 1'b0;
      spi_max_bytes <= '0;
      spi_no_data <= 1'b0;
    end else begin
      seek_zero_req <= go_acc && is_rtz;
      ovw_start <= go_acc && san_ok && sa == scd_pkg::SA_OVW;
      crypto_start <= go_acc && san_ok && sa == scd_pkg::SA_CRYPTO;
      exit_fail_start <= go_acc && san_ok && san_exit_act;
      spi_start <= go_acc && is_spi && !spi_res;
      if (go_acc && san_ok && sa == scd_pkg::SA_OVW) begin
        ovw_count <= cnt;
        invert_r <= ovw_r[scd_pkg::INVERT_BIT];
      end
      if (go_acc && is_spi && !spi_res) begin
        spi_protocol <= b1;
        spi_proto_info <= b1 == 8'h00;
        spi_pad_en <= inc512;
        spi_max_bytes <= spi_len;
        spi_no_data <= !held_r;
      end
    end
  end

  // Retained security results: a new result wins over any clear.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      held_r <= 1'b0;
      held_nexus_r <= 8'h00;
    end else if (spo_result) begin
      held_r <= 1'b1;
      held_nexus_r <= spo_nexus;
    end else if (held_clr) begin
      held_r <= 1'b0;
    end
  end

  // Overwrite fill stream: pattern restarts per block, inverts per pass.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pidx_r <= '0;
      inv_r <= 1'b0;
      fill_byte <= 8'h00;
    end else begin
      if (ovw_start || fill_block_start) begin
        pidx_r <= '0;
      end else if (fill_next && !fill_prot) begin
        pidx_r <= pidx_r == pat_last ? '0 : pidx_r + 1'b1;
      end
      if (ovw_start) begin
        inv_r <= 1'b0;
      end else if (fill_pass_end && invert_r) begin
        inv_r <= !inv_r;
      end
      fill_byte <= (fill_prot ? scd_pkg::PROT_FILL : pat_mem[pidx_r]) ^
                   {8{inv_r}};
    end
  end

  property p_rtz_seek;
    @(posedge clk) disable iff (!reset_n)
      go_acc && is_rtz |=> seek_zero_req && state_r == scd_pkg::S_SEEK;
  endproperty
  a_rtz_seek: assert property (p_rtz_seek)
    else $error("return-to-zero did not start a seek");

  property p_san_hold;
    @(posedge clk) disable iff (!reset_n)
      state_r == scd_pkg::S_SAN && !immed_r && !san_done |=> !done_r;
  endproperty
  a_san_hold: assert property (p_san_hold)
    else $error("status reported before sanitize finished");

  property p_san_immed;
    @(posedge clk) disable iff (!reset_n)
      go_acc && san_ok && b1[scd_pkg::IMMED_BIT] |=> done_r && !check_r;
  endproperty
  a_san_immed: assert property (p_san_immed)
    else $error("immediate sanitize did not report good at once");

  property p_exit_deny;
    @(posedge clk) disable iff (!reset_n)
      go_acc && is_san && exit_deny |=> check_r && !exit_fail_start;
  endproperty
  a_exit_deny: assert property (p_exit_deny)
    else $error("exit failure mode accepted without permission");

  property p_pll;
    @(posedge clk) disable iff (!reset_n)
      go_acc && is_san && san_pll != 16'h0000 |=>
        check_r && asc_r == scd_pkg::ASC_INV_CDB;
  endproperty
  a_pll: assert property (p_pll)
    else $error("nonzero parameter list length not rejected");

  property p_sa_res;
    @(posedge clk) disable iff (!reset_n)
      go_acc && is_san && sa_res |=>
        check_r && sk_r == scd_pkg::SK_ILLEGAL && state_r == scd_pkg::S_IDLE;
  endproperty
  a_sa_res: assert property (p_sa_res)
    else $error("reserved service action not rejected");

  property p_pat_bad;
    @(posedge clk) disable iff (!reset_n)
      go_acc && is_san && !san_cdb_bad && sa == scd_pkg::SA_OVW && pat_bad
        |=> asc_r == scd_pkg::ASC_INV_PARM && !ovw_start;
  endproperty
  a_pat_bad: assert property (p_pat_bad)
    else $error("bad pattern length not rejected");

  property p_crypto;
    @(posedge clk) disable iff (!reset_n)
      crypto_start |-> state_r == scd_pkg::S_SAN && $past(go_acc);
  endproperty
  a_crypto: assert property (p_crypto)
    else $error("key replacement started without a sanitize");

  property p_spi_len;
    @(posedge clk) disable iff (!reset_n)
      go_acc && is_spi && !spi_res && inc512 |=>
        spi_max_bytes == {$past(alloc), 9'h000} && spi_pad_en;
  endproperty
  a_spi_len: assert property (p_spi_len)
    else $error("512-unit allocation length not scaled");

  property p_held;
    @(posedge clk) disable iff (!reset_n)
      held_r && !held_clr && !spo_result |=> held_r;
  endproperty
  a_held: assert property (p_held)
    else $error("security result dropped without cause");
endmodule // scd_decoder
`default_nettype wire

// file: inc/scd_pkg.sv
// Constants, field layouts and states for the sanitize and security decoder.
`default_nettype none
package scd_pkg;
  localparam logic [7:0] OP_RTZ = 8'h01;
  localparam logic [7:0] OP_SAN = 8'h48;
  localparam logic [7:0] OP_SPI = 8'ha2;
  localparam logic [4:0] SA_OVW = 5'h01;
  localparam logic [4:0] SA_CRYPTO = 5'h03;
  localparam logic [4:0] SA_EXIT = 5'h1f;
  localparam int IMMED_BIT = 7;
  localparam int FAILURE_EXIT_PERMIT_FLAG_BIT = 5;
  localparam int INC512_BIT = 7;
  localparam int INVERT_BIT = 7;
  localparam logic [7:0] PROTO_EXT_MAX = 8'h06;
  localparam logic [3:0] SK_GOOD = 4'h0;
  localparam logic [3:0] SK_MEDIUM = 4'h3;
  localparam logic [3:0] SK_ILLEGAL = 4'h5;
  localparam logic [7:0] ASC_NONE = 8'h00;
  localparam logic [7:0] ASC_INV_OP = 8'h20;
  localparam logic [7:0] ASC_INV_CDB = 8'h24;
  localparam logic [7:0] ASC_INV_PARM = 8'h26;
  localparam logic [7:0] ASC_SAN_FAIL = 8'h31;
  localparam logic [7:0] PROT_FILL = 8'hff;
  localparam int UNIT512_SHIFT = 9;
  localparam logic [15:0] BLK_LEN_RST = 16'h0200;
  localparam logic [7:0] OFF_CDB0 = 8'h00;
  localparam logic [7:0] OFF_CDB1 = 8'h04;
  localparam logic [7:0] OFF_CDB2 = 8'h08;
  localparam logic [7:0] OFF_CTRL = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_OVW = 8'h14;
  localparam logic [7:0] OFF_BLK = 8'h18;
  localparam logic [7:0] OFF_PAT = 8'h1c;
  localparam logic [7:0] OFF_SPI_LEN = 8'h20;
  localparam int CTRL_GO_BIT = 0;
  localparam int NEXUS_LSB = 8;
  localparam int ST_DONE = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_READY = 2;
  localparam int ST_FAILED = 3;
  localparam int ST_HELD = 4;
  localparam int ST_CHECK = 5;
  localparam int ST_NODATA = 6;
  localparam int ST_SK_LSB = 8;
  localparam int ST_ASC_LSB = 16;
  localparam int PAT_IDX_LSB = 8;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_SEEK = 2'b01,
    S_SAN = 2'b10
  } scd_state_e;
endpackage
`default_nettype wire

// file: verification/scd_decoder_tb.sv
// Self-checking bench for the sanitize and security command decoder.
`timescale 1ns/1ps
`default_nettype none
module scd_decoder_tb;
  logic clk, reset_n;
  logic [7:0] s_axi_awaddr, s_axi_araddr, fill_byte, spi_protocol;
  logic [7:0] spo_nexus, it_loss_nexus;
  logic [31:0] s_axi_wdata, s_axi_rdata, st;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, seek_zero_req, seek_done;
  logic [4:0] ovw_count;
  logic ovw_start, crypto_start, exit_fail_start, san_done, san_fail;
  logic fill_block_start, fill_next, fill_prot, fill_pass_end;
  logic spi_start, spi_proto_info, spi_pad_en, spi_no_data;
  logic [40:0] spi_max_bytes;
  logic spo_result, lu_reset, it_loss, fail_mode, slow;
  int n_fail, n_checks;
  int n_spi;
  always @(posedge clk) if (spi_start === 1'b1) n_spi++;
  scd_decoder i_scd_decoder (.*);
  scd_far_model i_scd_far_model (.*);
  always #4 clk = ~clk;
  task automatic check(input logic [40:0] seen, input logic [40:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    @(posedge clk);
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk);
      aw_ok |= s_axi_awready;
      w_ok |= s_axi_wready;
      if (aw_ok) s_axi_awvalid <= 1'b0;
      if (w_ok) s_axi_wvalid <= 1'b0;
    end while (!(aw_ok && w_ok));
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    st = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask
  task automatic issue(input logic [31:0] c0, c1, c2, input logic [7:0] nx);
    wr(scd_pkg::OFF_CDB0, c0);
    wr(scd_pkg::OFF_CDB1, c1);
    wr(scd_pkg::OFF_CDB2, c2);
    wr(scd_pkg::OFF_CTRL, {16'h0, nx, 8'h01});
    do rd(scd_pkg::OFF_STATUS); while (st[scd_pkg::ST_DONE] !== 1'b1);
  endtask
  task automatic sense(input logic [3:0] sk, input logic [7:0] asc);
    check({st[23:16], st[11:8], st[5]}, {asc, sk, sk != 4'h0});
  endtask
  task automatic fill(input logic [2:0] v, input logic [7:0] exp);
    @(posedge clk);
    {fill_block_start, fill_next, fill_pass_end} <= v;
    @(posedge clk);
    {fill_block_start, fill_next, fill_pass_end} <= 3'b000;
    repeat (2) @(posedge clk);
    check(fill_byte, exp);
  endtask
  task automatic ev(input logic [2:0] v, input logic [7:0] nx);
    @(posedge clk);
    {spo_result, lu_reset, it_loss} <= v;
    spo_nexus <= nx;
    it_loss_nexus <= nx;
    @(posedge clk);
    {spo_result, lu_reset, it_loss} <= 3'b000;
  endtask
  task automatic t_regs;
    rd(scd_pkg::OFF_BLK);
    check(st, 32'h200);
    rd(8'h40);
    check({rsp, st}, {scd_pkg::RESP_SLVERR, 32'h0});
    wr(8'h44, 32'h1);
    check(rsp, scd_pkg::RESP_SLVERR);
  endtask
  task automatic t_rezero;
    slow <= 1'b1;
    issue(32'h01, 32'h0, 32'h0, 8'h01);
    sense(scd_pkg::SK_GOOD, scd_pkg::ASC_NONE);
  endtask
  task automatic t_san_bad;
    logic [4:0] sa [5] = '{5'h00, 5'h02, 5'h04, 5'h1e, 5'h01};
    logic [31:0] ov [3] = '{32'h2, 32'h0500_0002, 32'h0200_0000};
    for (int i = 0; i < 5; i++) begin
      issue({16'h0, 3'b000, sa[i], 8'h48}, 32'h0, {31'h0, i == 4}, 8'h01);
      sense(scd_pkg::SK_ILLEGAL, scd_pkg::ASC_INV_CDB);
    end
    // Block length 4 makes a 5-byte pattern too long while within depth.
    wr(scd_pkg::OFF_BLK, 32'h4);
    for (int i = 0; i < 3; i++) begin
      wr(scd_pkg::OFF_OVW, ov[i]);
      issue(32'h0148, 32'h0, 32'h0, 8'h01);
      sense(scd_pkg::SK_ILLEGAL, scd_pkg::ASC_INV_PARM);
    end
    wr(scd_pkg::OFF_BLK, 32'h200);
  endtask
  task automatic t_ovw;
    wr(scd_pkg::OFF_OVW, 32'h0200_0082);
    wr(scd_pkg::OFF_PAT, 32'h00a5);
    wr(scd_pkg::OFF_PAT, 32'h013c);
    wr(scd_pkg::OFF_CDB0, 32'h0148);
    wr(scd_pkg::OFF_CTRL, 32'h0101);
    rd(scd_pkg::OFF_STATUS);
    check(st[1:0], 2'b10);
    check(ovw_count, 5'h02);
    fill(3'b100, 8'ha5);
    fill(3'b010, 8'h3c);
    fill(3'b010, 8'ha5);
    fill_prot <= 1'b1;
    fill(3'b000, 8'hff);
    fill_prot <= 1'b0;
    fill(3'b001, 8'h5a);
    do rd(scd_pkg::OFF_STATUS); while (st[scd_pkg::ST_DONE] !== 1'b1);
    sense(scd_pkg::SK_GOOD, scd_pkg::ASC_NONE);
  endtask
  task automatic t_fail;
    logic [7:0] b1 [2] = '{8'ha3, 8'h83};
    slow <= 1'b0;
    issue(32'h1f48, 32'h0, 32'h0, 8'h01);
    sense(scd_pkg::SK_GOOD, scd_pkg::ASC_NONE);
    for (int i = 0; i < 2; i++) begin
      fail_mode <= 1'b1;
      issue({16'h0, b1[i], 8'h48}, 32'h0, 32'h0, 8'h01);
      sense(scd_pkg::SK_GOOD, scd_pkg::ASC_NONE);
      do rd(scd_pkg::OFF_STATUS); while (st[scd_pkg::ST_READY] !== 1'b1);
      check(st[scd_pkg::ST_FAILED], 1'b1);
      fail_mode <= 1'b0;
      issue(32'h1f48, 32'h0, 32'h0, 8'h01);
      check({st[5], st[3]}, {i == 1, i == 1});
    end
  endtask
  task automatic t_spi;
    issue(32'h07a2, 32'h0, 32'h0, 8'h05);
    sense(scd_pkg::SK_ILLEGAL, scd_pkg::ASC_INV_CDB);
    issue(32'h00a2, 32'h80, 32'h0100, 8'h05);
    check({spi_proto_info, spi_pad_en, spi_no_data}, 3'b111);
    check(spi_max_bytes, 41'd512);
    ev(3'b100, 8'h05);
    ev(3'b001, 8'h06);
    issue(32'h01a2, 32'h0201_0000, 32'h0403, 8'h06);
    check({spi_protocol, spi_max_bytes}, {8'h01, 41'h01020304});
    check(st[scd_pkg::ST_HELD], 1'b1);
    issue(32'h01a2, 32'h0201_0000, 32'h0403, 8'h05);
    check({st[scd_pkg::ST_HELD], spi_no_data}, 2'b00);
    for (int i = 0; i < 2; i++) begin
      ev(3'b100, 8'h05);
      ev(i ? 3'b001 : 3'b010, 8'h05);
      rd(scd_pkg::OFF_STATUS);
      check(st[scd_pkg::ST_HELD], 1'b0);
    end
    check(n_spi, 32'd3);
  endtask
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    s_axi_wstrb = 4'hf;
    {s_axi_bready, s_axi_rready} = 2'b11;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid} = '0;
    {s_axi_wvalid, s_axi_arvalid, fill_block_start, fill_next} = '0;
    {fill_prot, fill_pass_end, spo_result, spo_nexus, lu_reset} = '0;
    {it_loss, it_loss_nexus, fail_mode, slow} = '0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    t_regs;
    t_rezero;
    t_ovw;
    t_san_bad;
    t_fail;
    t_spi;
    print_verdict;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    print_verdict;
  end
endmodule // scd_decoder_tb
`default_nettype wire

// file: verification/scd_far_model.sv
// Behavioural model of the seek and sanitize engines behind the decoder.
`timescale 1ns/1ps
`default_nettype none
module scd_far_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic seek_zero_req,
  output logic seek_done,
  input wire logic ovw_start,
  input wire logic crypto_start,
  input wire logic exit_fail_start,
  output logic san_done,
  output logic san_fail,
  input wire logic fail_mode,
  input wire logic slow
);
  int seek_cnt;
  int san_cnt;
  logic san_go;
  assign san_go = ovw_start | crypto_start | exit_fail_start;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      seek_cnt <= 0;
      san_cnt <= 0;
      seek_done <= 1'b0;
      san_done <= 1'b0;
      san_fail <= 1'b0;
    end else begin
      seek_done <= (seek_cnt == 1);
      san_done <= (san_cnt == 1);
      // Outside the done pulse the fail level is not valid, so it wobbles.
      san_fail <= (san_cnt == 1) ? fail_mode : ~san_fail;
      if (seek_zero_req) seek_cnt <= slow ? 200 : 2;
      else if (seek_cnt != 0) seek_cnt <= seek_cnt - 1;
      if (san_go) san_cnt <= slow ? 200 : 2;
      else if (san_cnt != 0) san_cnt <= san_cnt - 1;
    end
  end
endmodule // scd_far_model
`default_nettype wire
